// ===== src/sd_resp_crc_defines.svh
// Purpose: addresses, field positions, reset values and codes of the response/CRC status block
// Assumes: 32-bit register port with full byte addresses
// Notes:   definitions only
`ifndef SD_RESP_CRC_DEFINES_SVH
`define SD_RESP_CRC_DEFINES_SVH

// register byte addresses
`define ADDR_CONTROL      32'hb000_d000
`define ADDR_IRQ_ENABLE   32'hb000_d004
`define ADDR_STATUS       32'hb000_d020
`define ADDR_RESP_UPPER   32'hb000_d030
`define ADDR_RESP_LOWER   32'hb000_d034

// status and irq enable layout
`define BIT_BLOCK_DONE    0
`define BIT_CRC_ERROR     1
`define BIT_CRC7_OK       2
`define BIT_CRC16_OK      3
`define FLD_TOKEN_LO      4
`define FLD_TOKEN_HI      6
// control layout
`define BIT_CAPTURE_EN    0

// reset values
`define RST_RESP_UPPER    32'h0000_0000
`define RST_RESP_LOWER    8'h00
`define RST_TOKEN         3'h0

// write crc status token codes
`define TOKEN_POSITIVE    3'h2
`define TOKEN_NEGATIVE    3'h5
`define TOKEN_PROG_ERROR  3'h7

// response framing: 48 bits, crc covers the first 40
`define RESP_BITS         48
`define RESP_CNT_LAST     6'h2f
`define RESP_CRC_SPAN     6'h28
`define TOKEN_CNT_LAST    2'h2

// serial crc generators
`define CRC7_WIDTH        7
`define CRC7_POLY         16'h0009
`define CRC16_WIDTH       16
`define CRC16_POLY        16'h1021

`endif

// ===== src/sd_resp_crc_pkg.sv
// Purpose: types shared by the response/CRC status block
// Assumes: nothing
// Notes:   constants live in sd_resp_crc_defines.svh
`default_nettype none

package sd_resp_crc_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic       bit_val;
    logic       is_crc;
    logic       block_end;
  } data_in_t;

  typedef struct packed {
    logic       token_valid;
    logic       token_bit;
    logic       block_end;
  } data_out_t;

  typedef enum logic {
    RESP_IDLE,
    RESP_RECV
  } resp_state_t;

endpackage

`default_nettype wire

// ===== src/crc_serial_check.sv
// Purpose: bit-serial crc generator, msb first, zero preset
// Assumes: one bit per cycle while bit_valid_in is high
// Notes:   clear_in wins over a bit in the same cycle
`default_nettype none

module crc_serial_check #(
  parameter int unsigned WIDTH = 7,
  parameter logic [15:0] POLY  = 16'h0009
) (
  // clock, reset, enable
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  // serial data
  input  wire logic             clear_in,
  input  wire logic             bit_valid_in,
  input  wire logic             bit_in,
  // running remainder
  output logic [WIDTH-1:0]      crc_out
);

  logic [WIDTH-1:0] crc_q;
  logic [WIDTH-1:0] crc_d;
  logic             feedback;

  assign feedback = bit_in ^ crc_q[WIDTH-1];

  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    if (i == 0) begin : g_lsb
      assign crc_d[i] = clear_in ? 1'b0 : (bit_valid_in ? feedback : crc_q[i]);
    end else begin : g_upper
      assign crc_d[i] = clear_in ? 1'b0 :
                        (bit_valid_in ? (crc_q[i-1] ^ (feedback & POLY[i])) : crc_q[i]);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_q <= '0;
    end else if (ce_in) begin
      crc_q <= crc_d;
    end
  end

  assign crc_out = crc_q;

endmodule // crc_serial_check

`default_nettype wire

// ===== src/sd_host_response_crc_status.sv
// Purpose: captures card response tokens, checks crc-7/crc-16/crc status, keeps status flags
// Assumes: data bits and token bits arrive from the sd engine on clk_sys_in; cmd pin is async
// Notes:   one level interrupt; flags are write-one-to-clear
`include "sd_resp_crc_defines.svh"
`default_nettype none

module sd_host_response_crc_status (
  // clock, reset, enable
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       ce_in,
  // register port
  input  wire sd_resp_crc_pkg::reg_req_t  reg_req_in,
  output logic [31:0]                     rd_data_out,
  // card command line and engine bit strobe
  input  wire logic                       cmd_pin_in,
  input  wire logic                       cmd_tick_in,
  // data-in and data-out streams from the sd engine
  input  wire sd_resp_crc_pkg::data_in_t  data_in_in,
  input  wire sd_resp_crc_pkg::data_out_t data_out_in,
  input  wire logic                       multi_block_in,
  // results
  output logic                            transfer_abort_out,
  output logic                            capture_busy_out,
  output logic                            irq_out
);

  sd_resp_crc_pkg::resp_state_t state_q;
  sd_resp_crc_pkg::resp_state_t state_d;

  logic                    cmd_meta_q;
  logic                    cmd_sync_q;
  logic [5:0]              resp_cnt_q;
  logic [`RESP_BITS-1:0]   resp_shift_q;
  logic [`RESP_BITS-1:0]   resp_shift_d;
  logic [31:0]             response_upper_word_q;
  logic [7:0]              response_low_byte_q;
  logic                    response_capture_enable_q;
  logic [1:0]              sd_irq_enable_q;
  logic                    block_done_flag_q;
  logic                    crc_error_flag_q;
  logic                    crc7_ok_q;
  logic                    crc16_ok_q;
  logic [2:0]              write_crc_token_status_q;
  logic [2:0]              token_shift_q;
  logic [1:0]              token_cnt_q;
  logic [15:0]             crc16_rx_q;
  logic [31:0]             rd_data_q;
  logic                    irq_q;
  logic                    abort_q;
  logic                    busy_q;

  logic [`CRC7_WIDTH-1:0]  crc7_calc;
  logic [`CRC16_WIDTH-1:0] crc16_calc;

  // register decode
  wire wr_control = reg_req_in.wr && (reg_req_in.addr == `ADDR_CONTROL);
  wire wr_irq_en  = reg_req_in.wr && (reg_req_in.addr == `ADDR_IRQ_ENABLE);
  wire wr_status  = reg_req_in.wr && (reg_req_in.addr == `ADDR_STATUS);
  wire blk_clr    = wr_status && reg_req_in.wdata[`BIT_BLOCK_DONE];
  wire crc_clr    = wr_status && reg_req_in.wdata[`BIT_CRC_ERROR];

  // response receiver
  wire start_seen = (state_q == sd_resp_crc_pkg::RESP_IDLE) && response_capture_enable_q &&
                    cmd_tick_in && !cmd_sync_q;
  wire resp_bit   = (state_q == sd_resp_crc_pkg::RESP_RECV) && cmd_tick_in;
  wire crc7_feed  = resp_bit && (resp_cnt_q < `RESP_CRC_SPAN);
  wire resp_done  = resp_bit && (resp_cnt_q == `RESP_CNT_LAST);
  assign resp_shift_d = {resp_shift_q[`RESP_BITS-2:0], cmd_sync_q};
  // the end bit is at position 0, crc-7 just above it
  wire crc7_match = (resp_shift_d[7:1] == crc7_calc);

  // data-in checker
  wire din_data   = data_in_in.valid && !data_in_in.is_crc;
  wire din_crc    = data_in_in.valid && data_in_in.is_crc;
  wire din_end    = data_in_in.block_end;
  wire crc16_good = (crc16_calc == crc16_rx_q);

  // write crc status token
  wire       token_done = data_out_in.token_valid && (token_cnt_q == `TOKEN_CNT_LAST);
  wire [2:0] token_d    = {token_shift_q[1:0], data_out_in.token_bit};
  wire       token_bad  = token_done && (token_d != `TOKEN_POSITIVE);

  // events
  wire multi_fail   = multi_block_in && ((din_end && !crc16_good) || token_bad);
  wire crc_err_ev   = (resp_done && !crc7_match) || (din_end && !crc16_good) || token_bad;
  wire blk_done_ev  = din_end || data_out_in.block_end || multi_fail;
  // a same-cycle event keeps the flag set
  wire blk_flag_d   = blk_done_ev || (block_done_flag_q && !blk_clr);
  wire crc_flag_d   = crc_err_ev || (crc_error_flag_q && !crc_clr);
  wire irq_d        = (blk_flag_d && sd_irq_enable_q[`BIT_BLOCK_DONE]) ||
                      (crc_flag_d && sd_irq_enable_q[`BIT_CRC_ERROR]);

  // read mux; unmapped addresses read zero
  wire [31:0] status_word = {25'h0, write_crc_token_status_q, crc16_ok_q, crc7_ok_q,
                             crc_error_flag_q, block_done_flag_q};
  wire [31:0] rd_mux =
    (reg_req_in.addr == `ADDR_CONTROL)    ? {31'h0, response_capture_enable_q} :
    (reg_req_in.addr == `ADDR_IRQ_ENABLE) ? {30'h0, sd_irq_enable_q} :
    (reg_req_in.addr == `ADDR_STATUS)     ? status_word :
    (reg_req_in.addr == `ADDR_RESP_UPPER) ? response_upper_word_q :
    (reg_req_in.addr == `ADDR_RESP_LOWER) ? {24'h0, response_low_byte_q} : 32'h0;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sd_resp_crc_pkg::RESP_IDLE: begin
        if (start_seen) begin
          state_d = sd_resp_crc_pkg::RESP_RECV;
        end
      end
      sd_resp_crc_pkg::RESP_RECV: begin
        if (resp_done) begin
          state_d = sd_resp_crc_pkg::RESP_IDLE;
        end
      end
    endcase
  end

  crc_serial_check #(
    .WIDTH (`CRC7_WIDTH),
    .POLY  (`CRC7_POLY)
  ) u_crc7 (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .clear_in     (state_q == sd_resp_crc_pkg::RESP_IDLE),
    .bit_valid_in (crc7_feed),
    .bit_in       (cmd_sync_q),
    .crc_out      (crc7_calc)
  );

  crc_serial_check #(
    .WIDTH (`CRC16_WIDTH),
    .POLY  (`CRC16_POLY)
  ) u_crc16 (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .clear_in     (din_end),
    .bit_valid_in (din_data),
    .bit_in       (data_in_in.bit_val),
    .crc_out      (crc16_calc)
  );

  // cmd pin synchroniser; only the second stage is read
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_meta_q <= 1'b1;
      cmd_sync_q <= 1'b1;
    end else if (ce_in) begin
      cmd_meta_q <= cmd_pin_in;
      cmd_sync_q <= cmd_meta_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q      <= sd_resp_crc_pkg::RESP_IDLE;
      resp_cnt_q   <= 6'h00;
      resp_shift_q <= '0;
    end else if (ce_in) begin
      state_q <= state_d;
      if (start_seen) begin
        resp_cnt_q   <= 6'h01;
        resp_shift_q <= '0;
      end else if (resp_bit) begin
        resp_cnt_q   <= resp_cnt_q + 6'h01;
        resp_shift_q <= resp_shift_d;
      end
    end
  end

  // captured response and crc-7 result
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      response_upper_word_q <= `RST_RESP_UPPER;
      response_low_byte_q   <= `RST_RESP_LOWER;
      crc7_ok_q             <= 1'b0;
    end else if (ce_in && resp_done) begin
      response_upper_word_q <= resp_shift_d[47:16];
      response_low_byte_q   <= resp_shift_d[15:8];
      crc7_ok_q             <= crc7_match;
    end
  end

  // software re-arming wins over the hardware disarm at the end of a response
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      response_capture_enable_q <= 1'b0;
      sd_irq_enable_q           <= 2'h0;
    end else if (ce_in) begin
      if (wr_control) begin
        response_capture_enable_q <= reg_req_in.wdata[`BIT_CAPTURE_EN];
      end else if (resp_done) begin
        response_capture_enable_q <= 1'b0;
      end
      if (wr_irq_en) begin
        sd_irq_enable_q <= reg_req_in.wdata[1:0];
      end
    end
  end

  // data-in crc and write token capture
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc16_rx_q               <= 16'h0000;
      crc16_ok_q               <= 1'b0;
      token_shift_q            <= 3'h0;
      token_cnt_q              <= 2'h0;
      write_crc_token_status_q <= `RST_TOKEN;
    end else if (ce_in) begin
      if (din_crc) begin
        crc16_rx_q <= {crc16_rx_q[14:0], data_in_in.bit_val};
      end
      if (din_end) begin
        crc16_ok_q <= crc16_good;
      end
      if (data_out_in.token_valid) begin
        token_shift_q <= token_d;
        token_cnt_q   <= token_done ? 2'h0 : token_cnt_q + 2'h1;
      end
      if (token_done) begin
        write_crc_token_status_q <= token_d;
      end
    end
  end

  // flags, interrupt and registered outputs
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      block_done_flag_q <= 1'b0;
      crc_error_flag_q  <= 1'b0;
      irq_q             <= 1'b0;
      abort_q           <= 1'b0;
      busy_q            <= 1'b0;
      rd_data_q         <= 32'h0;
    end else if (ce_in) begin
      block_done_flag_q <= blk_flag_d;
      crc_error_flag_q  <= crc_flag_d;
      irq_q             <= irq_d;
      abort_q           <= multi_fail;
      busy_q            <= (state_d == sd_resp_crc_pkg::RESP_RECV);
      rd_data_q         <= reg_req_in.rd ? rd_mux : 32'h0;
    end
  end

  assign rd_data_out        = rd_data_q;
  assign irq_out            = irq_q;
  assign transfer_abort_out = abort_q;
  assign capture_busy_out   = busy_q;

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_multi_fail;
    ce_in && multi_fail;
  endsequence

  property p_crc7_status;
    ce_in && resp_done |=> (crc7_ok_q == $past(crc7_match));
  endproperty
  a_crc7_status: assert property (p_crc7_status) else $error("crc7 status wrong");

  property p_crc_err_set;
    ce_in && crc_err_ev |=> crc_error_flag_q && (irq_out || !$past(sd_irq_enable_q[1]));
  endproperty
  a_crc_err_set: assert property (p_crc_err_set) else $error("crc flag not set");

  property p_no_crc_resp;
    ce_in && resp_done && !crc7_match |=> crc_error_flag_q && !crc7_ok_q;
  endproperty
  a_no_crc_resp: assert property (p_no_crc_resp) else $error("crc7 miss not flagged");

  property p_crc_clear;
    ce_in && crc_clr && !crc_err_ev |=> !crc_error_flag_q;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc flag not cleared");

  property p_blk_set;
    ce_in && (din_end || data_out_in.block_end) |=> block_done_flag_q;
  endproperty
  a_blk_set: assert property (p_blk_set) else $error("block done not set");

  property p_abort;
    s_multi_fail |=> transfer_abort_out && block_done_flag_q ##1
                     (!transfer_abort_out || $past(multi_fail) || !$past(ce_in));
  endproperty
  a_abort: assert property (p_abort) else $error("multi-block abort missing");

  property p_blk_hold;
    block_done_flag_q && !(ce_in && blk_clr) |=> block_done_flag_q;
  endproperty
  a_blk_hold: assert property (p_blk_hold) else $error("block done lost");

  property p_resp_store;
    ce_in && resp_done |=> (response_upper_word_q == $past(resp_shift_d[47:16])) &&
                           (response_low_byte_q == $past(resp_shift_d[15:8]));
  endproperty
  a_resp_store: assert property (p_resp_store) else $error("response not stored");

  property p_token;
    ce_in && token_done |=> (write_crc_token_status_q == $past(token_d));
  endproperty
  a_token: assert property (p_token) else $error("token status wrong");

  property p_crc16_status;
    ce_in && din_end |=> (crc16_ok_q == $past(crc16_good));
  endproperty
  a_crc16_status: assert property (p_crc16_status) else $error("crc16 status wrong");

  property p_set_wins;
    ce_in && blk_done_ev && blk_clr |=> block_done_flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

endmodule // sd_host_response_crc_status

`default_nettype wire

// ===== verification/sd_card_model.sv
// Purpose: behavioural sd card: response tokens, data-in blocks, crc status tokens
// Assumes: every change lands just after a rising edge of clk_sys_in
// Notes:   cmd idles high (pull-up); released data lines show the inverse of the last bit
`default_nettype none

module sd_card_model (
  // clock
  input  wire logic                      clk_sys_in,
  // card side
  output var logic                       cmd_pin_out,
  output var logic                       cmd_tick_out,
  output var sd_resp_crc_pkg::data_in_t  din_out,
  output var sd_resp_crc_pkg::data_out_t dout_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_pin_out  = 1'b1;
    cmd_tick_out = 1'b0;
    din_out      = '0;
    dout_out     = '0;
  end

  // three edges from pin change to tick so the two sync flops have settled
  task automatic send_resp(input logic [47:0] r);
    for (int i = 47; i >= 0; i--) begin
      @(posedge clk_sys_in);
      cmd_pin_out  <= r[i];
      cmd_tick_out <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      cmd_tick_out <= 1'b1;
    end
    @(posedge clk_sys_in);
    cmd_pin_out  <= 1'b1;
    cmd_tick_out <= 1'b0;
  endtask

  task automatic send_block(input logic [15:0] d, input logic [15:0] c);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_sys_in);
      din_out.valid   <= 1'b1;
      din_out.bit_val <= (i > 15) ? d[i-16] : c[i];
      din_out.is_crc  <= (i < 16);
    end
    @(posedge clk_sys_in);
    din_out.valid     <= 1'b0;
    din_out.is_crc    <= 1'b0;
    din_out.bit_val   <= ~din_out.bit_val;
    din_out.block_end <= 1'b1;
    @(posedge clk_sys_in);
    din_out.block_end <= 1'b0;
  endtask

  task automatic send_token(input logic [2:0] t);
    for (int i = 2; i >= 0; i--) begin
      @(posedge clk_sys_in);
      dout_out.token_valid <= 1'b1;
      dout_out.token_bit   <= t[i];
    end
    @(posedge clk_sys_in);
    dout_out.token_valid <= 1'b0;
    dout_out.token_bit   <= ~dout_out.token_bit;
    dout_out.block_end   <= 1'b1;
    @(posedge clk_sys_in);
    dout_out.block_end   <= 1'b0;
  endtask
endmodule // sd_card_model

`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench for the response capture and crc status block
// Assumes: ce_in held high except for one write in the reset test; register port driven right after rising edges
// Notes:   expected crc values come from local serial crc functions
`include "sd_resp_crc_defines.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       clk_sys_in;
  logic                       rst_n_in;
  logic                       ce_in;
  sd_resp_crc_pkg::reg_req_t  req;
  logic [31:0]                rd_data_out;
  logic                       cmd_pin;
  logic                       cmd_tick;
  sd_resp_crc_pkg::data_in_t  din;
  sd_resp_crc_pkg::data_out_t dout;
  logic                       multi_block;
  logic                       transfer_abort_out;
  logic                       capture_busy_out;
  logic                       irq_out;
  int                         num_errors;
  int                         n_compared;
  int                         n_abort;

  sd_host_response_crc_status dut_u (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .reg_req_in(req), .rd_data_out(rd_data_out),
    .cmd_pin_in(cmd_pin), .cmd_tick_in(cmd_tick),
    .data_in_in(din), .data_out_in(dout), .multi_block_in(multi_block),
    .transfer_abort_out(transfer_abort_out), .capture_busy_out(capture_busy_out),
    .irq_out(irq_out)
  );

  sd_card_model card_u (
    .clk_sys_in(clk_sys_in), .cmd_pin_out(cmd_pin), .cmd_tick_out(cmd_tick),
    .din_out(din), .dout_out(dout)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) if (transfer_abort_out === 1'b1) n_abort <= n_abort + 1;

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction

  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  function automatic logic [47:0] make_resp(input logic [37:0] b, input logic bad);
    return {2'b00, b, crc7({2'b00, b}) ^ {6'h00, bad}, 1'b1};
  endfunction

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    @(negedge clk_sys_in);
    chk(rd_data_out, e);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (capture_busy_out !== 1'b0) begin
      @(posedge clk_sys_in);
      n++;
      if (n > 50) begin
        num_errors++;
        results();
      end
    end
    repeat (2) @(posedge clk_sys_in);
  endtask

  task automatic capture(input logic [47:0] r, input logic busy);
    fork
      card_u.send_resp(r);
      begin
        repeat (20) @(negedge clk_sys_in);
        chk({31'h0, capture_busy_out}, {31'h0, busy});
      end
    join
    wait_idle();
  endtask

  task automatic t_reset();
    chk_reg(`ADDR_STATUS, 32'h0);
    chk_reg(`ADDR_RESP_UPPER, 32'h0);
    chk_reg(`ADDR_RESP_LOWER, 32'h0);
    wr(`ADDR_RESP_UPPER, 32'hffff_ffff);
    chk_reg(`ADDR_RESP_UPPER, 32'h0);
    chk_reg(32'hb000_d03c, 32'h0);
    // a write taken while the enable is low must not land
    ce_in <= 1'b0;
    wr(`ADDR_IRQ_ENABLE, 32'h3);
    ce_in <= 1'b1;
    chk_reg(`ADDR_IRQ_ENABLE, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_resp();
    logic [47:0] r;
    r = make_resp(38'h2a_5c31_e7b9, 1'b0);
    wr(`ADDR_IRQ_ENABLE, 32'h3);
    wr(`ADDR_CONTROL, 32'h1);
    capture(r, 1'b1);
    chk_reg(`ADDR_RESP_UPPER, r[47:16]);
    chk_reg(`ADDR_RESP_LOWER, {24'h0, r[15:8]});
    chk_reg(`ADDR_STATUS, 32'h4);
    chk_reg(`ADDR_CONTROL, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    $display("test good response done");
  endtask

  task automatic t_bad_resp();
    logic [47:0] r;
    r = make_resp(38'h15_0f0f_3c3c, 1'b1);
    wr(`ADDR_CONTROL, 32'h1);
    capture(r, 1'b1);
    chk_reg(`ADDR_STATUS, 32'h2);
    chk_reg(`ADDR_RESP_UPPER, r[47:16]);
    chk({31'h0, irq_out}, 32'h1);
    wr(`ADDR_STATUS, 32'h0);
    chk_reg(`ADDR_STATUS, 32'h2);
    wr(`ADDR_STATUS, 32'h2);
    chk_reg(`ADDR_STATUS, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    capture(make_resp(38'h3f_ffff_0000, 1'b0), 1'b0);
    chk_reg(`ADDR_RESP_UPPER, r[47:16]);
    $display("test bad response done");
  endtask

  task automatic t_data_in();
    card_u.send_block(16'h5aa3, crc16(16'h5aa3));
    repeat (2) @(posedge clk_sys_in);
    chk_reg(`ADDR_STATUS, 32'h9);
    chk({31'h0, irq_out}, 32'h1);
    wr(`ADDR_STATUS, 32'h2);
    chk_reg(`ADDR_STATUS, 32'h9);
    wr(`ADDR_STATUS, 32'h1);
    chk_reg(`ADDR_STATUS, 32'h8);
    // clear strobe lands on the same edge as block_end: the set must win
    fork
      card_u.send_block(16'h00ff, crc16(16'h00ff));
      begin
        repeat (32) @(posedge clk_sys_in);
        wr(`ADDR_STATUS, 32'h1);
      end
    join
    chk_reg(`ADDR_STATUS, 32'h9);
    multi_block <= 1'b1;
    n_abort = 0;
    card_u.send_block(16'h1234, crc16(16'h1234) ^ 16'h0100);
    repeat (2) @(posedge clk_sys_in);
    chk(n_abort, 32'h1);
    chk_reg(`ADDR_STATUS, 32'h3);
    // engine reset after a genuine crc error
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    chk_reg(`ADDR_STATUS, 32'h0);
    $display("test data-in done");
  endtask

  task automatic t_tokens();
    logic [2:0] tok [3] = '{`TOKEN_POSITIVE, `TOKEN_NEGATIVE, `TOKEN_PROG_ERROR};
    logic bad;
    foreach (tok[i]) begin
      bad = (tok[i] != `TOKEN_POSITIVE);
      n_abort = 0;
      card_u.send_token(tok[i]);
      repeat (2) @(posedge clk_sys_in);
      chk(n_abort, {31'h0, bad});
      chk_reg(`ADDR_STATUS, {25'h0, tok[i], 2'h0, bad, 1'b1});
      wr(`ADDR_STATUS, 32'h3);
    end
    $display("test data-out tokens done");
  endtask

  initial begin
    rst_n_in    = 1'b0;
    ce_in       = 1'b1;
    req         = '0;
    multi_block = 1'b0;
    num_errors  = 0;
    n_compared  = 0;
    n_abort     = 0;
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_resp();
    t_bad_resp();
    t_data_in();
    t_tokens();
    results();
  end
endmodule // testbench

`default_nettype wire
